//--- hdl/ebct_clk_sel.sv
// Count clock selector: prescaler taps and external clock edge detection.
// Assumes the external count clock is synchronous to i_clk.
`timescale 1ns/1ns
module ebct_clk_sel
  import ebct_pkg::*;
(
  // System
  input  wire logic   i_clk,
  input  wire logic   i_nrst,
  input  wire logic   i_standby,
  // External count clock
  input  wire logic   i_ext_clk,
  // Tick to core
  ebct_tick_if.src    tk
);

  logic [PRE_W-1:0] prescale;
  logic [PRE_W-1:0] next_prescale;
  logic             ext_prev;
  logic             rise;
  logic             fall;

  assign next_prescale = prescale + 10'h001;
  assign rise = i_ext_clk & ~ext_prev;
  assign fall = ~i_ext_clk & ext_prev;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prescale <= '0;
    end else if (i_standby) begin
      prescale <= '0;
    end else begin
      prescale <= next_prescale;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= i_ext_clk;
    end
  end

  // Internal ticks fire on the falling edge of the divided clock
  function automatic logic tap_fall(input int tap);
    tap_fall = prescale[tap] & ~next_prescale[tap];
  endfunction

  // One tick per period of the selected source; one per edge when both edges are selected
  always_comb begin
    case (tk.clk_sel)
      EBCT_CK_DIV8:  tk.tick = tap_fall(TAP_DIV8);   // RL13
      EBCT_CK_DIV64: tk.tick = tap_fall(TAP_DIV64);  // RL13
      EBCT_CK_DIV1K: tk.tick = tap_fall(TAP_DIV1K);  // RL13
      EBCT_CK_RISE:  tk.tick = rise;                 // RL14
      EBCT_CK_FALL:  tk.tick = fall;                 // RL14
      EBCT_CK_BOTH:  tk.tick = rise | fall;          // RL14
      default:       tk.tick = 1'b0;                 // RL23
    endcase
  end

endmodule

//--- hdl/ebct_out_ctl.sv
// Timer output pin logic: applies compare A and B actions with priority.
// Assumes compare pulses are one cycle wide and on the system clock.
`timescale 1ns/1ns
module ebct_out_ctl
  import ebct_pkg::*;
(
  // System
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_standby,
  // Compare events and selects
  input  wire logic       i_match_a,
  input  wire logic       i_match_b,
  input  wire logic [3:0] i_out_sel,
  // Pin
  output logic            o_level,
  output logic            o_oe
);

  ebct_out_act_t act_a;
  ebct_out_act_t act_b;
  ebct_out_act_t act;

  // Higher code means higher priority: toggle, 1, 0, keep
  function automatic ebct_out_act_t pick(input ebct_out_act_t x,
                                         input ebct_out_act_t y);
    pick = (x > y) ? x : y;
  endfunction

  always_comb begin
    act_a = i_match_a ? ebct_out_act_t'(i_out_sel[OUT_SEL_A_LSB +: 2])
                      : EBCT_OUT_KEEP;                        // RL10
    act_b = i_match_b ? ebct_out_act_t'(i_out_sel[OUT_SEL_B_LSB +: 2])
                      : EBCT_OUT_KEEP;                        // RL9
    act   = pick(act_a, act_b);                               // RL24
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_level <= 1'b0;                                        // RL12
    end else if (i_standby) begin
      o_level <= 1'b0;
    end else begin
      case (act)
        EBCT_OUT_LOW:    o_level <= 1'b0;
        EBCT_OUT_HIGH:   o_level <= 1'b1;
        EBCT_OUT_TOGGLE: o_level <= ~o_level;
        default:         o_level <= o_level;
      endcase
    end
  end

  assign o_oe = |i_out_sel;                                   // RL11

endmodule

//--- hdl/ebct_pkg.sv
// Constants and encodings for the eight-bit compare timer.
// Assumes an APB slave with 32-bit words, one register per aligned word.
package ebct_pkg;

  // Register indices; byte address is index times four
  localparam logic [15:0] IDX_TIMER_CONTROL_REG  = 16'hfed0;
  localparam logic [15:0] IDX_TIMER_STATUS_OUT   = 16'hfed1;
  localparam logic [15:0] IDX_COMPARE_CONSTANT_A = 16'hfed2;
  localparam logic [15:0] IDX_COMPARE_CONSTANT_B = 16'hfed3;
  localparam logic [15:0] IDX_UP_COUNTER         = 16'hfed4;
  localparam logic [17:0] ADDR_TIMER_CONTROL_REG  = {IDX_TIMER_CONTROL_REG, 2'b00};
  localparam logic [17:0] ADDR_TIMER_STATUS_OUT   = {IDX_TIMER_STATUS_OUT, 2'b00};
  localparam logic [17:0] ADDR_COMPARE_CONSTANT_A = {IDX_COMPARE_CONSTANT_A, 2'b00};
  localparam logic [17:0] ADDR_COMPARE_CONSTANT_B = {IDX_COMPARE_CONSTANT_B, 2'b00};
  localparam logic [17:0] ADDR_UP_COUNTER         = {IDX_UP_COUNTER, 2'b00};
  localparam int          ADDR_W = 18;

  // Reset values
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_STATUS   = 8'h10;
  localparam logic [7:0] RST_CONSTANT = 8'hff;
  localparam logic [7:0] RST_COUNTER  = 8'h00;
  localparam logic [7:0] CNT_MAX      = 8'hff;

  // Status/output-select fields
  localparam int BIT_COMPARE_B_FLAG = 7;
  localparam int BIT_COMPARE_A_FLAG = 6;
  localparam int BIT_WRAP_FLAG      = 5;
  localparam int BIT_RESERVED       = 4;
  localparam int OUT_SEL_B_LSB      = 2;
  localparam int OUT_SEL_A_LSB      = 0;

  // Control fields
  localparam int BIT_COMPARE_B_IRQ_ENABLE = 7;
  localparam int BIT_COMPARE_A_IRQ_ENABLE = 6;
  localparam int BIT_WRAP_IRQ_ENABLE      = 5;
  localparam int CLEAR_SELECT_LSB         = 3;
  localparam int CLOCK_SELECT_LSB         = 0;

  // Output actions on a compare match
  typedef enum logic [1:0] {
    EBCT_OUT_KEEP   = 2'b00,
    EBCT_OUT_LOW    = 2'b01,
    EBCT_OUT_HIGH   = 2'b10,
    EBCT_OUT_TOGGLE = 2'b11
  } ebct_out_act_t;

  typedef enum logic [1:0] {
    EBCT_CLR_NONE  = 2'b00,
    EBCT_CLR_CMP_A = 2'b01,
    EBCT_CLR_CMP_B = 2'b10,
    EBCT_CLR_EXT   = 2'b11
  } ebct_clr_sel_t;

  typedef enum logic [2:0] {
    EBCT_CK_STOP0  = 3'b000,
    EBCT_CK_DIV8   = 3'b001,
    EBCT_CK_DIV64  = 3'b010,
    EBCT_CK_DIV1K  = 3'b011,
    EBCT_CK_STOP1  = 3'b100,
    EBCT_CK_RISE   = 3'b101,
    EBCT_CK_FALL   = 3'b110,
    EBCT_CK_BOTH   = 3'b111
  } ebct_clk_sel_t;

  // Prescaler tap positions: divide by 8, 64 and 1024
  localparam int PRE_W      = 10;
  localparam int TAP_DIV8   = 2;
  localparam int TAP_DIV64  = 5;
  localparam int TAP_DIV1K  = 9;

  // External count clock least pulse width, in tenths of a system period
  localparam int EXT_PULSE_SINGLE_TENTHS = 15;
  localparam int EXT_PULSE_BOTH_TENTHS   = 25;
  localparam int EXT_PULSE_SINGLE_CYC = (EXT_PULSE_SINGLE_TENTHS + 9) / 10;
  localparam int EXT_PULSE_BOTH_CYC   = (EXT_PULSE_BOTH_TENTHS + 9) / 10;

endpackage

//--- hdl/ebct_tick_if.sv
// Interface carrying the count tick from the clock selector to the core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface ebct_tick_if;
  logic       tick;
  logic [2:0] clk_sel;
  modport src (output tick, input  clk_sel);
  modport dst (input  tick, output clk_sel);
endinterface

//--- hdl/ebct_top.sv
// Eight-bit compare timer: APB registers, up counter, compares, flags,
// clearing and interrupt/transfer-engine request lines.
// Assumes an APB master on i_clk and inputs synchronous to i_clk.
//
// Contract
// RL1 - Counter equal to constant B sets flag B, bit 7.
// RL2 - Counter equal to constant A sets flag A, bit 6.
// RL3 - Counter wrap from 0xff to 0x00 sets wrap flag.
// RL4 - Writing 0 to bits 7..5 clears flags; 1 does nothing.
// RL5 - A zero write clears a flag only after it read as 1.
// RL6 - Transfer engine service of A or B clears that flag.
// RL7 - Status bit 4 ignores writes, reads 1.
// RL8 - Status register is 0x10 after reset and in standby.
// RL9 - Bits 3..2 choose the compare B output action.
// RL10 - Bits 1..0 choose the compare A output action.
// RL11 - Output-select all zero: output not driven to pin.
// RL12 - Output is 0 from reset to first compare match.
// RL13 - Counter steps once per period of selected source.
// RL14 - External clock counts on rise, fall or both edges.
// RL15 - External pulses last 1.5 periods, 2.5 for both edges.
// RL16 - Match fires in the last cycle before the counter moves.
// RL17 - Clear select A or B clears counter on that match.
// RL18 - Clear select 11: external reset rising edge clears counter.
// RL19 - Three requests, each high while flag and enable are 1.
// RL20 - Priority: compare A, compare B, then wrap.
// RL21 - Compare requests go to transfer engine; wrap to CPU only.
// RL22 - Clear select: 00 never, 01 A, 10 B, 11 external reset.
// RL23 - Clock select: stop, /8, /64, /1024, stop, rise, fall, both.
// RL24 - Conflicting simultaneous actions: toggle, 1, 0, no change.
// RL25 - A flag event beats a simultaneous software clear.
`timescale 1ns/1ns
module ebct_top
  import ebct_pkg::*;
(
  // System
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_standby,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Timer pins
  input  wire logic              i_external_count_clock,
  input  wire logic              i_external_counter_reset,
  output logic                   o_timer_output_pin,
  output logic                   o_timer_output_pin_oe,
  // Interrupt controller
  output logic                   o_compare_a_irq,
  output logic                   o_compare_b_irq,
  output logic                   o_wrap_irq,
  output logic [1:0]             o_irq_top,
  // Transfer engine service
  output logic                   o_compare_a_xfer_req,
  output logic                   o_compare_b_xfer_req,
  input  wire logic              i_compare_a_xfer_ack,
  input  wire logic              i_compare_b_xfer_ack
);

  // Registers
  logic [7:0] timer_control_reg;
  logic [7:0] compare_constant_a;
  logic [7:0] compare_constant_b;
  logic [7:0] up_counter;
  logic       compare_a_flag;
  logic       compare_b_flag;
  logic       wrap_flag;
  logic [3:0] out_sel;
  // Flag-clear arming
  logic       armed_a;
  logic       armed_b;
  logic       armed_w;
  logic       ext_rst_prev;

  ebct_tick_if tk ();

  logic       acc;
  logic       wr;
  logic       rd;
  logic       lane0;
  logic       hit_ctl;
  logic       hit_sts;
  logic       hit_ca;
  logic       hit_cb;
  logic       hit_cnt;
  logic       mapped;
  logic       match_a;
  logic       match_b;
  logic       wrap;
  logic       clr_cnt;
  logic       clr_a;
  logic       clr_b;
  logic       clr_w;
  logic [7:0] sts_rd;
  logic [7:0] rd_byte;
  ebct_clr_sel_t clr_sel;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    hit = (a[ADDR_W-1:2] == r[ADDR_W-1:2]);
  endfunction

  // APB decode: no wait states; unmapped access errors
  assign acc     = i_psel & i_penable;
  assign lane0   = i_pstrb[0];
  assign hit_ctl = hit(i_paddr, ADDR_TIMER_CONTROL_REG);
  assign hit_sts = hit(i_paddr, ADDR_TIMER_STATUS_OUT);
  assign hit_ca  = hit(i_paddr, ADDR_COMPARE_CONSTANT_A);
  assign hit_cb  = hit(i_paddr, ADDR_COMPARE_CONSTANT_B);
  assign hit_cnt = hit(i_paddr, ADDR_UP_COUNTER);
  assign mapped  = hit_ctl | hit_sts | hit_ca | hit_cb | hit_cnt;
  assign wr      = acc & i_pwrite & lane0 & mapped;
  // Arm at the setup edge, where the returned data is captured
  assign rd      = i_psel & ~i_penable & ~i_pwrite & mapped;
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & ~mapped;

  assign tk.clk_sel = timer_control_reg[CLOCK_SELECT_LSB +: 3];
  assign clr_sel    = ebct_clr_sel_t'(timer_control_reg[CLEAR_SELECT_LSB +: 2]);

  // Match fires with the tick in the count's last cycle;
  // a same-cycle constant write inhibits it
  assign match_a = tk.tick & (up_counter == compare_constant_a)
                   & ~(wr & hit_ca);                          // RL16
  assign match_b = tk.tick & (up_counter == compare_constant_b)
                   & ~(wr & hit_cb);                          // RL16
  assign wrap    = tk.tick & (up_counter == CNT_MAX);

  // Counter clear source selection
  always_comb begin
    case (clr_sel)
      EBCT_CLR_CMP_A: clr_cnt = match_a;                      // RL17
      EBCT_CLR_CMP_B: clr_cnt = match_b;                      // RL17
      EBCT_CLR_EXT:   clr_cnt = i_external_counter_reset
                                & ~ext_rst_prev;              // RL18
      default:        clr_cnt = 1'b0;                         // RL22
    endcase
  end

  ebct_clk_sel u_clk_sel (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_standby (i_standby),
    .i_ext_clk (i_external_count_clock),
    .tk        (tk)
  );

  ebct_out_ctl u_out_ctl (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_standby (i_standby),
    .i_match_a (match_a),
    .i_match_b (match_b),
    .i_out_sel (out_sel),
    .o_level   (o_timer_output_pin),
    .o_oe      (o_timer_output_pin_oe)
  );

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_rst_prev <= 1'b0;
    end else begin
      ext_rst_prev <= i_external_counter_reset;
    end
  end

  // Counter: clear beats write, write beats increment
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      up_counter <= RST_COUNTER;
    end else if (i_standby) begin
      up_counter <= RST_COUNTER;
    end else if (clr_cnt) begin
      up_counter <= RST_COUNTER;                              // RL17
    end else if (wr & hit_cnt) begin
      up_counter <= i_pwdata[7:0];
    end else if (tk.tick) begin
      up_counter <= up_counter + 8'h01;                       // RL13
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer_control_reg  <= RST_CONTROL;
      compare_constant_a <= RST_CONSTANT;
      compare_constant_b <= RST_CONSTANT;
    end else if (i_standby) begin
      timer_control_reg  <= RST_CONTROL;
      compare_constant_a <= RST_CONSTANT;
      compare_constant_b <= RST_CONSTANT;
    end else if (wr) begin
      if (hit_ctl) begin
        timer_control_reg <= i_pwdata[7:0];
      end
      if (hit_ca) begin
        compare_constant_a <= i_pwdata[7:0];
      end
      if (hit_cb) begin
        compare_constant_b <= i_pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_sel <= RST_STATUS[3:0];                             // RL8
    end else if (i_standby) begin
      out_sel <= RST_STATUS[3:0];                             // RL8
    end else if (wr & hit_sts) begin
      out_sel <= i_pwdata[3:0];                               // RL9 RL10
    end
  end

  // Zero write clears only an armed flag
  assign clr_a = wr & hit_sts & ~i_pwdata[BIT_COMPARE_A_FLAG] & armed_a; // RL4
  assign clr_b = wr & hit_sts & ~i_pwdata[BIT_COMPARE_B_FLAG] & armed_b; // RL4
  assign clr_w = wr & hit_sts & ~i_pwdata[BIT_WRAP_FLAG] & armed_w;      // RL4

  // Set wins over any clear so an event is never lost
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      compare_a_flag <= RST_STATUS[BIT_COMPARE_A_FLAG];       // RL8
      compare_b_flag <= RST_STATUS[BIT_COMPARE_B_FLAG];       // RL8
      wrap_flag      <= RST_STATUS[BIT_WRAP_FLAG];            // RL8
    end else if (i_standby) begin
      compare_a_flag <= RST_STATUS[BIT_COMPARE_A_FLAG];       // RL8
      compare_b_flag <= RST_STATUS[BIT_COMPARE_B_FLAG];       // RL8
      wrap_flag      <= RST_STATUS[BIT_WRAP_FLAG];            // RL8
    end else begin
      if (match_a) begin
        compare_a_flag <= 1'b1;                               // RL2 RL25
      end else if (clr_a | i_compare_a_xfer_ack) begin
        compare_a_flag <= 1'b0;                               // RL5 RL6
      end
      if (match_b) begin
        compare_b_flag <= 1'b1;                               // RL1 RL25
      end else if (clr_b | i_compare_b_xfer_ack) begin
        compare_b_flag <= 1'b0;                               // RL5 RL6
      end
      if (wrap) begin
        wrap_flag <= 1'b1;                                    // RL3 RL25
      end else if (clr_w) begin
        wrap_flag <= 1'b0;                                    // RL5
      end
    end
  end

  // Arm on a status read that sees the flag set; disarm once it is clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      armed_a <= 1'b0;
      armed_b <= 1'b0;
      armed_w <= 1'b0;
    end else begin
      if (!compare_a_flag || i_standby) begin
        armed_a <= 1'b0;
      end else if (rd & hit_sts) begin
        armed_a <= 1'b1;                                      // RL5
      end
      if (!compare_b_flag || i_standby) begin
        armed_b <= 1'b0;
      end else if (rd & hit_sts) begin
        armed_b <= 1'b1;                                      // RL5
      end
      if (!wrap_flag || i_standby) begin
        armed_w <= 1'b0;
      end else if (rd & hit_sts) begin
        armed_w <= 1'b1;                                      // RL5
      end
    end
  end

  assign sts_rd = {compare_b_flag, compare_a_flag, wrap_flag,
                   1'b1, out_sel};                            // RL7

  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctl) begin
      rd_byte = timer_control_reg;
    end else if (hit_sts) begin
      rd_byte = sts_rd;
    end else if (hit_ca) begin
      rd_byte = compare_constant_a;
    end else if (hit_cb) begin
      rd_byte = compare_constant_b;
    end else if (hit_cnt) begin
      rd_byte = up_counter;
    end
  end

  // Read data registered at setup, valid in access
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      o_prdata <= {24'h00_0000, rd_byte};
    end
  end

  // Request levels follow flag and enable
  assign o_compare_a_irq = compare_a_flag
                           & timer_control_reg[BIT_COMPARE_A_IRQ_ENABLE]; // RL19
  assign o_compare_b_irq = compare_b_flag
                           & timer_control_reg[BIT_COMPARE_B_IRQ_ENABLE]; // RL19
  assign o_wrap_irq      = wrap_flag
                           & timer_control_reg[BIT_WRAP_IRQ_ENABLE];      // RL19

  // Only compare requests reach the transfer engine
  assign o_compare_a_xfer_req = o_compare_a_irq;              // RL21
  assign o_compare_b_xfer_req = o_compare_b_irq;              // RL21

  // Highest pending request: 1 = A, 2 = B, 3 = wrap, 0 = none
  always_comb begin
    if (o_compare_a_irq) begin
      o_irq_top = 2'b01;                                      // RL20
    end else if (o_compare_b_irq) begin
      o_irq_top = 2'b10;                                      // RL20
    end else if (o_wrap_irq) begin
      o_irq_top = 2'b11;                                      // RL20
    end else begin
      o_irq_top = 2'b00;
    end
  end

endmodule

//--- verif/ebct_top_sva.sv
// Checker for ebct_top, bound to it below.
// Sees only top-level ports; one domain on i_clk, reset i_nrst.
`timescale 1ns/1ns
module ebct_top_sva
  import ebct_pkg::*;
(
  // System
  input wire logic              i_clk,
  input wire logic              i_nrst,
  input wire logic              i_standby,
  // APB
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       o_prdata,
  // Pin and requests
  input wire logic              o_timer_output_pin,
  input wire logic              o_timer_output_pin_oe,
  input wire logic              o_compare_a_irq,
  input wire logic              o_compare_b_irq,
  input wire logic              o_wrap_irq,
  input wire logic [1:0]        o_irq_top,
  input wire logic              o_compare_a_xfer_req,
  input wire logic              o_compare_b_xfer_req,
  input wire logic              i_compare_a_xfer_ack,
  input wire logic              i_compare_b_xfer_ack
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic st_acc;
  assign st_acc = i_psel && i_penable &&
                  (i_paddr[ADDR_W-1:2] == IDX_TIMER_STATUS_OUT);

  property p_prio;
    o_irq_top == (o_compare_a_irq ? 2'h1 : o_compare_b_irq ? 2'h2 :
                  o_wrap_irq ? 2'h3 : 2'h0);
  endproperty
  a_prio: assert property (p_prio) else $error("irq order wrong");
  property p_req;
    o_compare_a_xfer_req == o_compare_a_irq &&
    o_compare_b_xfer_req == o_compare_b_irq;
  endproperty
  a_req: assert property (p_req) else $error("xfer req wrong");
  property p_ack_a;
    i_compare_a_xfer_ack && o_compare_a_irq |=> !o_compare_a_irq;
  endproperty
  a_ack_a: assert property (p_ack_a) else $error("ack a kept");
  property p_ack_b;
    i_compare_b_xfer_ack && o_compare_b_irq |=> !o_compare_b_irq;
  endproperty
  a_ack_b: assert property (p_ack_b) else $error("ack b kept");
  property p_oe;
    $changed(o_timer_output_pin_oe) |->
      $past((st_acc && i_pwrite) || i_standby);
  endproperty
  a_oe: assert property (p_oe) else $error("oe moved alone");
  property p_pin;
    $changed(o_timer_output_pin) |->
      $past(o_timer_output_pin_oe) || $past(i_standby);
  endproperty
  a_pin: assert property (p_pin) else $error("pin moved idle");
  property p_stby;
    $past(i_standby) |-> !(o_compare_a_irq || o_compare_b_irq ||
      o_wrap_irq || o_timer_output_pin_oe || o_timer_output_pin);
  endproperty
  a_stby: assert property (p_stby) else $error("standby kept");
  property p_bit4;
    st_acc && !i_pwrite |-> o_prdata[4] && o_prdata[31:8] == 24'h0;
  endproperty
  a_bit4: assert property (p_bit4) else $error("bit 4 low");

  c_top_a: cover property (o_irq_top == 2'h1);
  c_ack: cover property (i_compare_a_xfer_ack);
  c_pin: cover property ($rose(o_timer_output_pin));
endmodule

bind ebct_top ebct_top_sva i_sva (.*);

//--- verif/ebct_top_tb.sv
// Bench for ebct_top: registers, count clock, flags, pin, engine.
// Assumes pready answers each access; a cycle ceiling cuts hangs.
`timescale 1ns/1ns
module ebct_top_tb;
  import ebct_pkg::*;
  logic              i_clk = 0, i_nrst = 0, i_standby = 0;
  logic              i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [ADDR_W-1:0] i_paddr = '0;
  logic [31:0]       i_pwdata = '0, o_prdata;
  logic [3:0]        i_pstrb = 4'hf;
  logic              i_external_count_clock = 0;
  logic              i_external_counter_reset = 0;
  logic              o_pready, o_pslverr, o_timer_output_pin;
  logic              o_timer_output_pin_oe, o_compare_a_irq;
  logic              o_compare_b_irq, o_wrap_irq;
  logic [1:0]        o_irq_top;
  logic              o_compare_a_xfer_req, o_compare_b_xfer_req;
  logic              i_compare_a_xfer_ack, i_compare_b_xfer_ack;
  logic              xen = 0, serr;
  logic [7:0]        q;
  int                failures = 0, checked = 0, cyc = 0;
  localparam logic [17:0] CTL = ADDR_TIMER_CONTROL_REG;
  localparam logic [17:0] STS = ADDR_TIMER_STATUS_OUT;
  localparam logic [17:0] CNT = ADDR_UP_COUNTER;

  ebct_top i_dut (.*);
  ebct_xfer_model i_xfer (.i_clk, .i_nrst, .i_en(xen), .i_slow(1'h1),
    .i_req_a(o_compare_a_xfer_req), .i_req_b(o_compare_b_xfer_req),
    .o_ack_a(i_compare_a_xfer_ack), .o_ack_b(i_compare_b_xfer_ack));

  always #20 i_clk = ~i_clk;

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready, then idles a cycle
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [7:0] d);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_clk);
    i_penable <= 1'h1;
    do @(posedge i_clk); while (o_pready !== 1'h1);
    q = o_prdata[7:0];
    serr = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clk);
  endtask

  task automatic rc(input logic [17:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    chk(q, e);
  endtask

  // Three cycles per level keeps both-edge counting legal
  task automatic pulse(input int n);
    repeat (n) begin
      i_external_count_clock <= 1'h1;
      repeat (3) @(posedge i_clk);
      i_external_count_clock <= 1'h0;
      repeat (3) @(posedge i_clk);
    end
  endtask

  task automatic s_reset();
    rc(CTL, 8'h00);
    rc(STS, 8'h10);
    rc(ADDR_COMPARE_CONSTANT_A, 8'hff);
    rc(CNT, 8'h00);
    chk({o_timer_output_pin, o_timer_output_pin_oe}, 2'h0);
    apb(1'h0, 18'h0, 8'h00);
    chk(serr, 1'h1);
    apb(1'h1, STS, 8'h00);
    rc(STS, 8'h10);
  endtask

  task automatic s_cmp_a();
    apb(1'h1, CTL, 8'h45);
    apb(1'h1, ADDR_COMPARE_CONSTANT_A, 8'h02);
    apb(1'h1, STS, 8'h03);
    chk(o_timer_output_pin_oe, 1'h1);
    apb(1'h1, CNT, 8'h00);
    pulse(2);
    rc(STS, 8'h13);
    pulse(1);
    chk({o_timer_output_pin, o_compare_a_irq, o_irq_top}, 4'hd);
    apb(1'h1, STS, 8'h03);
    chk(o_compare_a_irq, 1'h1);
    rc(STS, 8'h53);
    apb(1'h1, STS, 8'he3);
    chk(o_compare_a_irq, 1'h1);
    apb(1'h1, STS, 8'h03);
    rc(STS, 8'h13);
  endtask

  task automatic s_both();
    apb(1'h1, ADDR_COMPARE_CONSTANT_A, 8'h05);
    apb(1'h1, ADDR_COMPARE_CONSTANT_B, 8'h05);
    apb(1'h1, STS, 8'h0b);
    apb(1'h1, CTL, 8'hc5);
    pulse(3);
    chk({o_timer_output_pin, o_compare_b_irq, o_irq_top}, 4'h5);
    xen <= 1'h1;
    repeat (12) @(posedge i_clk);
    chk({o_compare_a_irq, o_compare_b_irq}, 2'h0);
    xen <= 1'h0;
    rc(STS, 8'h1b);
  endtask

  task automatic s_wrap();
    apb(1'h1, CTL, 8'h25);
    apb(1'h1, CNT, 8'hff);
    pulse(1);
    chk({o_wrap_irq, o_irq_top, o_compare_a_xfer_req}, 4'he);
    rc(STS, 8'h3b);
    i_standby <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_standby <= 1'h0;
    @(posedge i_clk);
    chk({o_timer_output_pin, o_timer_output_pin_oe, o_wrap_irq}, 3'h0);
    rc(STS, 8'h10);
  endtask

  task automatic s_clear();
    logic [7:0] ex [4] = '{8'h03, 8'h01, 8'h00, 8'h00};
    apb(1'h1, ADDR_COMPARE_CONSTANT_A, 8'h01);
    apb(1'h1, ADDR_COMPARE_CONSTANT_B, 8'h02);
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, CTL, {3'h0, i[1:0], 3'h5});
      apb(1'h1, CNT, 8'h00);
      pulse(3);
      i_external_counter_reset <= 1'h1;
      repeat (3) @(posedge i_clk);
      i_external_counter_reset <= 1'h0;
      rc(CNT, ex[i]);
    end
  endtask

  task automatic s_clk();
    logic [2:0] md [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [7:0] ex [5] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h04};
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, CTL, {5'h00, md[i]});
      apb(1'h1, CNT, 8'h00);
      pulse(2);
      rc(CNT, ex[i]);
    end
    apb(1'h1, CTL, 8'h01);
    apb(1'h1, CNT, 8'h00);
    repeat (80) @(posedge i_clk);
    apb(1'h0, CNT, 8'h00);
    chk(q >= 8'h09 && q <= 8'h0b, 1'h1);
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'h1;
    @(posedge i_clk);
    s_reset();
    s_cmp_a();
    s_both();
    s_wrap();
    s_clear();
    s_clk();
    print_verdict();
  end
endmodule

//--- verif/ebct_xfer_model.sv
// Transfer-engine model: serves compare requests with a one-cycle ack.
// Assumes request levels on i_clk; i_slow waits three cycles first.
`timescale 1ns/1ns
module ebct_xfer_model (
  // System
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Bench control
  input  wire logic i_en,
  input  wire logic i_slow,
  // Requests and acks
  input  wire logic i_req_a,
  input  wire logic i_req_b,
  output logic      o_ack_a,
  output logic      o_ack_b
);
  logic [1:0] wait_cnt;
  logic       busy;
  assign busy = i_en & (i_req_a | i_req_b) & ~o_ack_a & ~o_ack_b;
  // A before B; wrap never reaches this engine
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_cnt <= 2'h0;
      o_ack_a  <= 1'h0;
      o_ack_b  <= 1'h0;
    end else if (busy && wait_cnt == (i_slow ? 2'h3 : 2'h0)) begin
      wait_cnt <= 2'h0;
      o_ack_a  <= i_req_a;
      o_ack_b  <= ~i_req_a;
    end else begin
      wait_cnt <= busy ? wait_cnt + 2'h1 : 2'h0;
      o_ack_a  <= 1'h0;
      o_ack_b  <= 1'h0;
    end
  end
endmodule
